// [hdl/tir_pkg.sv]
// Constants of the transceiver interrupt request logic
// What this block does
// - Drive interrupt line high on any unmasked event
// - Any state status bit change raises line
// - Power-on flag rising edge raises line
// - Auxiliary-power flag rising edge raises line
// - Status read or delete command clears those
// - Transmit fill threshold or empty raises line
// - Buffer write, control write, delete clear transmit
// - Receive fill threshold or receive error raises
// - Bit-check success raises line without pattern mode
// - Buffer read, control write, delete clear receive
// - Transparent mode disables buffer fill interrupts
// - Pending counter: load up, send down
// - Pattern mode swaps Manchester for NRZ coding
package tir_pkg;
    // APB geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_CFG4 = 8'h0c;
    localparam logic [7:0] ADDR_CFG5 = 8'h10;
    localparam logic [7:0] ADDR_CFG6 = 8'h14;
    localparam logic [7:0] ADDR_TXBUF = 8'h18;
    localparam logic [7:0] ADDR_RXBUF = 8'h1c;
    localparam logic [7:0] ADDR_CMD = 8'h20;
    localparam logic [7:0] ADDR_COUNT = 8'h24;
    // Interrupt source positions in status and mask
    localparam int N_SRC = 6;
    localparam int SRC_STATE = 0;
    localparam int SRC_PON = 1;
    localparam int SRC_AUX = 2;
    localparam int SRC_TX = 3;
    localparam int SRC_RX = 4;
    localparam int SRC_BCHK = 5;
    localparam logic [5:0] MASK_RST = 6'h3f;
    // Status readback field positions
    localparam int STAT_STATE_LSB = 8;
    localparam int STAT_PON_BIT = 12;
    localparam int STAT_AUX_BIT = 13;
    // Control register fields
    localparam int CTRL_W = 5;
    localparam int CTL_TMODE = 0;
    localparam int CTL_PMODE = 1;
    localparam int CTL_THR_LO = 2;
    localparam int CTL_THR_HI = 3;
    localparam int CTL_RXDIR = 4;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    // Command register: delete pending interrupts
    localparam int CMD_DEL_IRQ = 0;
    // Count readback positions
    localparam int CNT_TX_LSB = 0;
    localparam int CNT_RX_LSB = 8;
    // Byte counters and thresholds
    localparam int N_STATE = 4;
    localparam int CNT_W = 5;
    localparam logic [4:0] CNT_MAX = 5'h1f;
    localparam logic [4:0] THR_0 = 5'h00;
    localparam logic [4:0] THR_4 = 5'h04;
    localparam logic [4:0] THR_8 = 5'h08;
    localparam logic [4:0] THR_12 = 5'h0c;
endpackage

// [hdl/tir_cnt_if.sv]
// Carrier between the top logic and one byte counter
`timescale 1ns/100ps
interface tir_cnt_if;
    logic up; // Count one byte in
    logic down; // Count one byte out
    logic clr; // Clear count to zero
    logic [tir_pkg::CNT_W-1:0] thr; // Threshold level
    logic [tir_pkg::CNT_W-1:0] count; // Present count
    logic hit_up; // Pulse: reached threshold counting up
    logic hit_dn; // Pulse: reached threshold counting down
    modport ctl (output up, down, clr, thr, input count, hit_up, hit_dn);
    modport cnt (input up, down, clr, thr, output count, hit_up, hit_dn);
endinterface

// [hdl/tir_flag.sv]
// Sticky interrupt flag whose set wins over its clear
`timescale 1ns/100ps
module tir_flag (
    input wire logic clk,
    input wire logic rst,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    logic q_d; // Next flag value

    // Set beats a clear in the same cycle so no event is lost
    always_comb begin
        q_d = set | (q & ~clr);
    end

    // Flag register, empty after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= 1'b0;
        end else begin
            q <= q_d;
        end
    end
endmodule // tir_flag

// [hdl/tir_cnt.sv]
// Pending byte counter with threshold crossing pulses
`timescale 1ns/100ps
module tir_cnt (
    input wire logic clk,
    input wire logic rst,
    tir_cnt_if.cnt cif
);
    logic [tir_pkg::CNT_W-1:0] cnt_q; // Byte count
    logic [tir_pkg::CNT_W-1:0] cnt_d; // Next byte count
    logic inc; // Effective increment
    logic dec; // Effective decrement

    // Up and down together cancel; saturate at both ends
    always_comb begin
        inc = cif.up & ~cif.down & (cnt_q != tir_pkg::CNT_MAX);
        dec = cif.down & ~cif.up & (cnt_q != '0);
        cnt_d = cnt_q;
        if (cif.clr) begin
            cnt_d = '0;
        end else if (inc) begin
            cnt_d = cnt_q + 5'h01;
        end else if (dec) begin
            cnt_d = cnt_q - 5'h01;
        end
        cif.count = cnt_q;
        cif.hit_up = ~cif.clr & inc & (cnt_d == cif.thr);
        cif.hit_dn = ~cif.clr & dec & (cnt_d == cif.thr);
    end

    // Count register
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule // tir_cnt

// [hdl/tir_top.sv]
// Interrupt request logic of the transceiver with its APB register file
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
module tir_top (
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tir_pkg::ADDR_W-1:0] paddr,
    input wire logic [tir_pkg::DATA_W-1:0] pwdata,
    output logic [tir_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Status and datapath events, same clock
    input wire logic [tir_pkg::N_STATE-1:0] state_status_bits,
    input wire logic power_on_flag,
    input wire logic aux_power_flag,
    input wire logic tx_byte_sent,
    input wire logic rx_byte_stored,
    input wire logic rx_error,
    input wire logic bitcheck_ok,
    input wire logic [7:0] rx_data,
    // Datapath controls
    output logic [7:0] tx_data,
    output logic tx_load,
    output logic rx_take,
    output logic buf_reset,
    output logic manchester_en,
    output logic transparent,
    // Interrupt line to the host
    output logic irq
);
    // Register state
    logic [tir_pkg::N_SRC-1:0] mask_q, mask_d; // Interrupt mask
    logic [tir_pkg::CTRL_W-1:0] ctrl_q, ctrl_d; // Control register
    logic [7:0] cfg4_q, cfg4_d; // Configuration 4
    logic [7:0] cfg5_q, cfg5_d; // Configuration 5
    logic [7:0] cfg6_q, cfg6_d; // Configuration 6
    logic [7:0] txd_q, txd_d; // Last byte written for transmit
    logic txl_q, txl_d; // Transmit load pulse
    logic rxt_q, rxt_d; // Receive take pulse
    logic bres_q, bres_d; // Buffer reset pulse
    logic [tir_pkg::DATA_W-1:0] prdata_q, prdata_d; // Read data
    logic pready_q, pready_d; // Access phase ready
    logic pslverr_q, pslverr_d; // Unmapped address error
    logic irq_q, irq_d; // Interrupt line
    logic man_q, man_d; // Manchester enable, own flop so the pin has no gate
    // Edge detection state
    logic [tir_pkg::N_STATE-1:0] st_prev_q, st_prev_d; // Last state bits
    logic pon_prev_q, pon_prev_d; // Last power-on flag
    logic aux_prev_q, aux_prev_d; // Last auxiliary flag
    logic primed_q, primed_d; // First sample after reset taken

    // Decoded bus strobes
    logic setup; // Setup cycle of a transfer
    logic acc; // Completing access phase
    logic wr; // Completing write
    logic rd; // Completing read
    logic mapped; // Address hits a register
    // Host operations
    logic stat_rd; // Status register read
    logic ctl_wr; // Control or configuration write
    logic txbuf_wr; // Transmit buffer write
    logic rxbuf_rd; // Receive buffer read
    logic del_irq; // Delete interrupt command
    // Mode bits
    logic tmode; // Transparent mode
    logic pmode; // Pattern mode
    logic rxdir; // Receive direction
    logic [1:0] thr_sel; // Threshold select pair
    logic [tir_pkg::CNT_W-1:0] thr; // Decoded threshold
    // Interrupt sources
    logic [tir_pkg::N_SRC-1:0] ev; // Raising events
    logic [tir_pkg::N_SRC-1:0] clr; // Clearing operations
    logic [tir_pkg::N_SRC-1:0] pend; // Sticky pending flags

    tir_cnt_if tx_if(); // Transmit pending counter link
    tir_cnt_if rx_if(); // Receive stored counter link

    // Bus decode; the slave answers in the first access cycle
    always_comb begin
        setup = psel & ~penable;
        acc = psel & penable & pready_q;
        wr = acc & pwrite & ~pslverr_q;
        rd = acc & ~pwrite & ~pslverr_q;
        case (paddr)
            tir_pkg::ADDR_STATUS, tir_pkg::ADDR_MASK, tir_pkg::ADDR_CTRL,
            tir_pkg::ADDR_CFG4, tir_pkg::ADDR_CFG5, tir_pkg::ADDR_CFG6,
            tir_pkg::ADDR_TXBUF, tir_pkg::ADDR_RXBUF, tir_pkg::ADDR_CMD,
            tir_pkg::ADDR_COUNT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Host operations that act on interrupts
    always_comb begin
        stat_rd = rd & (paddr == tir_pkg::ADDR_STATUS);
        ctl_wr = wr & ((paddr == tir_pkg::ADDR_CTRL) | (paddr == tir_pkg::ADDR_CFG4)
                 | (paddr == tir_pkg::ADDR_CFG5) | (paddr == tir_pkg::ADDR_CFG6));
        txbuf_wr = wr & (paddr == tir_pkg::ADDR_TXBUF);
        rxbuf_rd = rd & (paddr == tir_pkg::ADDR_RXBUF);
        del_irq = wr & (paddr == tir_pkg::ADDR_CMD) & pwdata[tir_pkg::CMD_DEL_IRQ];
    end

    // Mode bits and threshold decode
    always_comb begin
        tmode = ctrl_q[tir_pkg::CTL_TMODE];
        pmode = ctrl_q[tir_pkg::CTL_PMODE];
        rxdir = ctrl_q[tir_pkg::CTL_RXDIR];
        thr_sel = {ctrl_q[tir_pkg::CTL_THR_HI], ctrl_q[tir_pkg::CTL_THR_LO]};
        case (thr_sel)
            2'h0: thr = tir_pkg::THR_0;
            2'h1: thr = tir_pkg::THR_4;
            2'h2: thr = tir_pkg::THR_8;
            default: thr = tir_pkg::THR_12;
        endcase
    end

    // Counter hookup; transparent mode holds both counters empty
    always_comb begin
        tx_if.up = txbuf_wr & ~tmode;
        tx_if.down = tx_byte_sent;
        tx_if.clr = ctl_wr | tmode;
        tx_if.thr = thr;
        rx_if.up = rx_byte_stored;
        rx_if.down = rxbuf_rd;
        rx_if.clr = ctl_wr | tmode;
        rx_if.thr = thr;
    end

    tir_cnt u_tx_cnt (
        .clk(ref_clk),
        .rst(rst),
        .cif(tx_if.cnt)
    );

    tir_cnt u_rx_cnt (
        .clk(ref_clk),
        .rst(rst),
        .cif(rx_if.cnt)
    );

    // Raising events; the first sample after reset only primes the state bit history
    always_comb begin
        ev = '0;
        ev[tir_pkg::SRC_STATE] = primed_q & (state_status_bits != st_prev_q);
        ev[tir_pkg::SRC_PON] = power_on_flag & ~pon_prev_q;
        ev[tir_pkg::SRC_AUX] = aux_power_flag & ~aux_prev_q;
        ev[tir_pkg::SRC_TX] = ~tmode & ~rxdir & tx_if.hit_dn;
        if (thr_sel == 2'h0) begin
            // Lowest select reports receive errors instead of a level
            ev[tir_pkg::SRC_RX] = ~tmode & rxdir & rx_error;
        end else begin
            ev[tir_pkg::SRC_RX] = ~tmode & rxdir & rx_if.hit_up;
        end
        ev[tir_pkg::SRC_BCHK] = ~pmode & rxdir & bitcheck_ok;
    end

    // Each source has its own clearing operations
    always_comb begin
        clr = '0;
        clr[tir_pkg::SRC_STATE] = stat_rd | del_irq;
        clr[tir_pkg::SRC_PON] = stat_rd | del_irq;
        clr[tir_pkg::SRC_AUX] = stat_rd | del_irq;
        clr[tir_pkg::SRC_TX] = txbuf_wr | ctl_wr | del_irq;
        clr[tir_pkg::SRC_RX] = rxbuf_rd | ctl_wr | del_irq;
        clr[tir_pkg::SRC_BCHK] = rxbuf_rd | ctl_wr | del_irq;
    end

    // One sticky flag per source; buffer flags survive a status read
    generate
        for (genvar i = 0; i < tir_pkg::N_SRC; i++) begin : g_flag
            tir_flag u_flag (
                .clk(ref_clk),
                .rst(rst),
                .set(ev[i]),
                .clr(clr[i]),
                .q(pend[i])
            );
        end
    endgenerate

    // Next register values from bus writes
    always_comb begin
        mask_d = mask_q;
        ctrl_d = ctrl_q;
        cfg4_d = cfg4_q;
        cfg5_d = cfg5_q;
        cfg6_d = cfg6_q;
        txd_d = txd_q;
        if (wr) begin
            case (paddr)
                tir_pkg::ADDR_MASK: mask_d = pwdata[tir_pkg::N_SRC-1:0];
                tir_pkg::ADDR_CTRL: ctrl_d = pwdata[tir_pkg::CTRL_W-1:0];
                tir_pkg::ADDR_CFG4: cfg4_d = pwdata[7:0];
                tir_pkg::ADDR_CFG5: cfg5_d = pwdata[7:0];
                tir_pkg::ADDR_CFG6: cfg6_d = pwdata[7:0];
                tir_pkg::ADDR_TXBUF: txd_d = pwdata[7:0];
                default: txd_d = txd_q; // Status, count and command store nothing
            endcase
        end
        // Transparent mode bypasses the buffer, so no bytes are loaded
        txl_d = txbuf_wr & ~tmode;
        rxt_d = rxbuf_rd & ~tmode;
        bres_d = ctl_wr;
        man_d = ~ctrl_d[tir_pkg::CTL_PMODE];
        // Level line: OR of every unmasked pending source
        irq_d = |(pend & mask_q);
        st_prev_d = state_status_bits;
        pon_prev_d = power_on_flag;
        aux_prev_d = aux_power_flag;
        primed_d = 1'b1;
    end

    // Read data is fetched in the setup cycle and held for the access cycle
    always_comb begin
        prdata_d = prdata_q;
        pready_d = setup;
        pslverr_d = setup & ~mapped;
        if (setup) begin
            prdata_d = '0;
            if (!pwrite) begin
                case (paddr)
                    tir_pkg::ADDR_STATUS: begin
                        prdata_d[tir_pkg::N_SRC-1:0] = pend;
                        prdata_d[tir_pkg::STAT_STATE_LSB +: tir_pkg::N_STATE] =
                            state_status_bits;
                        prdata_d[tir_pkg::STAT_PON_BIT] = power_on_flag;
                        prdata_d[tir_pkg::STAT_AUX_BIT] = aux_power_flag;
                    end
                    tir_pkg::ADDR_MASK: prdata_d[tir_pkg::N_SRC-1:0] = mask_q;
                    tir_pkg::ADDR_CTRL: prdata_d[tir_pkg::CTRL_W-1:0] = ctrl_q;
                    tir_pkg::ADDR_CFG4: prdata_d[7:0] = cfg4_q;
                    tir_pkg::ADDR_CFG5: prdata_d[7:0] = cfg5_q;
                    tir_pkg::ADDR_CFG6: prdata_d[7:0] = cfg6_q;
                    tir_pkg::ADDR_TXBUF: prdata_d[7:0] = txd_q;
                    tir_pkg::ADDR_RXBUF: prdata_d[7:0] = rx_data;
                    tir_pkg::ADDR_COUNT: begin
                        prdata_d[tir_pkg::CNT_TX_LSB +: tir_pkg::CNT_W] = tx_if.count;
                        prdata_d[tir_pkg::CNT_RX_LSB +: tir_pkg::CNT_W] = rx_if.count;
                    end
                    default: prdata_d = '0; // Command and unmapped read zero
                endcase
            end
        end
    end

    // Register every group; synchronous reset gives constants only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mask_q <= tir_pkg::MASK_RST;
            ctrl_q <= tir_pkg::CTRL_RST;
            cfg4_q <= tir_pkg::CFG_RST;
            cfg5_q <= tir_pkg::CFG_RST;
            cfg6_q <= tir_pkg::CFG_RST;
            txd_q <= 8'h00;
            txl_q <= 1'b0;
            rxt_q <= 1'b0;
            bres_q <= 1'b0;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
            man_q <= 1'b1;
            st_prev_q <= '0;
            pon_prev_q <= 1'b0;
            aux_prev_q <= 1'b0;
            primed_q <= 1'b0;
        end else begin
            mask_q <= mask_d;
            ctrl_q <= ctrl_d;
            cfg4_q <= cfg4_d;
            cfg5_q <= cfg5_d;
            cfg6_q <= cfg6_d;
            txd_q <= txd_d;
            txl_q <= txl_d;
            rxt_q <= rxt_d;
            bres_q <= bres_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
            man_q <= man_d;
            st_prev_q <= st_prev_d;
            pon_prev_q <= pon_prev_d;
            aux_prev_q <= aux_prev_d;
            primed_q <= primed_d;
        end
    end

    // Outputs straight from flip-flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign tx_data = txd_q;
    assign tx_load = txl_q;
    assign rx_take = rxt_q;
    assign buf_reset = bres_q;
    assign transparent = ctrl_q[tir_pkg::CTL_TMODE];
    assign manchester_en = man_q;
    assign irq = irq_q;
endmodule // tir_top

// [tb/tir_chk.sv]
// Concurrent checks on the ports of the interrupt request logic
`timescale 1ns/100ps
module tir_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tir_pkg::ADDR_W-1:0] paddr,
    input wire logic [tir_pkg::DATA_W-1:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [tir_pkg::N_STATE-1:0] state_status_bits,
    input wire logic power_on_flag,
    input wire logic aux_power_flag,
    input wire logic tx_byte_sent,
    input wire logic rx_byte_stored,
    input wire logic rx_error,
    input wire logic bitcheck_ok,
    input wire logic transparent,
    input wire logic tx_load,
    input wire logic irq
);
    logic [5:0] mask_q; // Shadow copy of the mask register
    logic [3:0] st_q; // State bits one cycle ago
    logic pon_q; // Power-on flag one cycle ago
    logic aux_q; // Auxiliary flag one cycle ago
    logic ev_any; // Some raising event is seen at this edge
    logic cmd_done; // Delete command completes at this edge
    logic wr_done; // Any write completes at this edge
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Edge history and mask shadow, kept like the design keeps them
    always_ff @(posedge ref_clk) begin
        st_q <= state_status_bits;
        pon_q <= rst ? 1'b0 : power_on_flag;
        aux_q <= rst ? 1'b0 : aux_power_flag;
        if (rst) begin
            mask_q <= tir_pkg::MASK_RST;
        end else if (wr_done && paddr == tir_pkg::ADDR_MASK) begin
            mask_q <= pwdata[5:0];
        end
    end
    assign wr_done = psel & penable & pready & pwrite;
    assign cmd_done = wr_done & (paddr == tir_pkg::ADDR_CMD) & pwdata[0];
    // Too wide on purpose: a spare event only weakens the clear check
    assign ev_any = (state_status_bits != st_q) | (power_on_flag & ~pon_q)
        | (aux_power_flag & ~aux_q) | tx_byte_sent | rx_byte_stored | rx_error | bitcheck_ok;
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_unmapped_err: assert property (pready |-> pslverr == (paddr > tir_pkg::ADDR_COUNT
        || paddr[1:0] != 2'b00)) else $error("slave error wrong");
    a_irq_reset_low: assert property ($past(rst) |-> !irq)
        else $error("irq high after reset");
    a_state_irq: assert property (state_status_bits != st_q && mask_q[0] && !$past(rst)
        && !$past(rst, 2) |-> ##[1:2] irq) else $error("state change gave no irq");
    a_pon_irq: assert property (power_on_flag && !pon_q && mask_q[1] |-> ##[1:2] irq)
        else $error("power-on rise gave no irq");
    a_aux_irq: assert property (aux_power_flag && !aux_q && mask_q[2] |-> ##[1:2] irq)
        else $error("aux rise gave no irq");
    a_cmd_clears_all: assert property (cmd_done && !ev_any |-> ##2 !irq)
        else $error("delete command left irq high");
    a_load_pulse: assert property (wr_done && paddr == tir_pkg::ADDR_TXBUF && !transparent
        |=> tx_load) else $error("buffer write gave no load");
endmodule // tir_chk
bind tir_top tir_chk u_chk (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .state_status_bits, .power_on_flag, .aux_power_flag, .tx_byte_sent,
    .rx_byte_stored, .rx_error, .bitcheck_ok, .transparent, .tx_load, .irq);

// [tb/tir_dp_model.sv]
// Behavioural model of the buffer datapath beside the interrupt logic
`timescale 1ns/100ps
module tir_dp_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tx_load,
    input wire logic rx_take,
    input wire logic buf_reset,
    input wire logic send,
    input wire logic push,
    input wire logic [7:0] push_data,
    output logic tx_byte_sent = 1'b0,
    output logic rx_byte_stored = 1'b0,
    output logic [7:0] rx_data = 8'ha5
);
    int pend = 0; // Bytes loaded and not yet sent
    logic [7:0] rxq[$]; // Received bytes awaiting the host
    logic [7:0] pat = 8'h3c; // Filler shown when nothing is buffered
    // One process: load counts up, send counts down, receive queues
    always @(posedge ref_clk) begin
        tx_byte_sent <= 1'b0;
        rx_byte_stored <= 1'b0;
        pat <= pat + 8'h3b;
        if (rst || buf_reset) begin
            pend = 0;
            rxq.delete();
        end else begin
            if (tx_load) pend++;
            if (send && pend > 0) begin
                pend--;
                tx_byte_sent <= 1'b1;
            end
            if (push) begin
                rxq.push_back(push_data);
                rx_byte_stored <= 1'b1;
            end
            if (rx_take && rxq.size() != 0) void'(rxq.pop_front());
        end
        // An empty buffer never shows a stale byte
        rx_data <= (rxq.size() != 0) ? rxq[0] : pat;
    end
endmodule // tir_dp_model

// [tb/transceiver_irq_logic_test.sv]
// Self-checking bench for the transceiver interrupt request logic
`timescale 1ns/100ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module transceiver_irq_logic_test;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, rx_data, tx_data, push_data = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] state_status_bits = 4'h0;
    logic power_on_flag = 1'b0, aux_power_flag = 1'b0, rx_error = 1'b0, bitcheck_ok = 1'b0;
    logic pready, pslverr, tx_byte_sent, rx_byte_stored, tx_load, rx_take, buf_reset;
    logic manchester_en, transparent, irq, send = 1'b0, push = 1'b0, probe = 1'b0;
    logic [32:0] expq[$]; // Expected results in issue order
    logic [32:0] e; // Oldest expectation taken off the queue
    logic [7:0] fb; // First byte of a receive burst
    logic [7:0] junk; // Byte nobody reads back
    logic [7:0] tw; // Last byte written to the transmit buffer
    logic probe_pins = 1'b0; // Mode pins and transmit byte are sampled
    integer seed = 98;
    int n_checks = 0, n_mismatch = 0;
    tir_top i_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .state_status_bits, .power_on_flag, .aux_power_flag, .tx_byte_sent,
        .rx_byte_stored, .rx_error, .bitcheck_ok, .rx_data, .tx_data, .tx_load, .rx_take,
        .buf_reset, .manchester_en, .transparent, .irq);
    tir_dp_model i_dp (.ref_clk, .rst, .tx_load, .rx_take, .buf_reset, .send, .push, .push_data,
        .tx_byte_sent, .rx_byte_stored, .rx_data);
    always #5 ref_clk = ~ref_clk;
    // Watcher: each completed read or irq probe consumes the oldest note
    always @(posedge ref_clk) begin
        if (psel && penable && pready && !pwrite) begin
            e = expq.pop_front();
            `CHK({pslverr, prdata}, e)
        end
        if (probe) begin
            e = expq.pop_front();
            `CHK({32'h0, irq}, e)
        end
        if (probe_pins) begin
            e = expq.pop_front();
            `CHK({23'h0, manchester_en, transparent, tx_data}, e)
        end
    end
    // One APB transfer; holds everything until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [32:0] x);
        if (!w) expq.push_back(x);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] x);
        apb(1'b0, a, 32'h0, x);
    endtask
    // Irq settles two edges after its cause, so the probe waits that long
    task automatic irq_is(input logic v);
        repeat (2) @(posedge ref_clk);
        expq.push_back({32'h0, v});
        probe <= 1'b1;
        @(posedge ref_clk);
        probe <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic pins_are(input logic [32:0] x);
        expq.push_back(x);
        probe_pins <= 1'b1;
        @(posedge ref_clk);
        probe_pins <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic push_rx(input int n, output logic [7:0] first);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            d = $random(seed);
            if (i == 0) first = d;
            push_data <= d;
            push <= 1'b1;
            @(posedge ref_clk);
            push <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watchdog: far beyond the few hundred cycles the sequence needs
    initial begin
        #200000;
        n_mismatch++;
        give_verdict;
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        irq_is(1'b0);
        rd(tir_pkg::ADDR_MASK, 33'h3f);
        rd(tir_pkg::ADDR_STATUS, 33'h0);
        rd(8'h40, 33'h100000000);
        state_status_bits <= 4'h5;
        irq_is(1'b1);
        rd(tir_pkg::ADDR_STATUS, 33'h501);
        irq_is(1'b0);
        power_on_flag <= 1'b1;
        irq_is(1'b1);
        wr(tir_pkg::ADDR_CMD, 32'h1);
        irq_is(1'b0);
        rd(tir_pkg::ADDR_STATUS, 33'h1500);
        wr(tir_pkg::ADDR_MASK, 32'h0);
        aux_power_flag <= 1'b1;
        irq_is(1'b0);
        rd(tir_pkg::ADDR_STATUS, 33'h3504);
        wr(tir_pkg::ADDR_MASK, 32'h3f);
        aux_power_flag <= 1'b0;
        @(posedge ref_clk);
        aux_power_flag <= 1'b1;
        irq_is(1'b1);
        rd(tir_pkg::ADDR_STATUS, 33'h3504);
        // Transmit: load past the threshold, then one send crosses it downward
        for (int k = 0; k < 4; k++) begin
            wr(tir_pkg::ADDR_CTRL, 32'(k << 2));
            repeat (4 * k + 1) wr(tir_pkg::ADDR_TXBUF, $random(seed));
            irq_is(1'b0);
            send <= 1'b1;
            @(posedge ref_clk);
            send <= 1'b0;
            irq_is(1'b1);
            rd(tir_pkg::ADDR_COUNT, 33'(4 * k));
            rd(tir_pkg::ADDR_STATUS, 33'h3508);
            irq_is(1'b1);
            tw = $random(seed);
            wr(tir_pkg::ADDR_TXBUF, {24'h0, tw});
            irq_is(1'b0);
        end
        // Receive: error at select 0, then fill levels 4, 8 and 12
        for (int k = 0; k < 4; k++) begin
            wr(tir_pkg::ADDR_CTRL, 32'h10 | 32'(k << 2));
            if (k == 0) begin
                rx_error <= 1'b1;
                @(posedge ref_clk);
                rx_error <= 1'b0;
                irq_is(1'b1);
                wr(tir_pkg::ADDR_CFG5, 32'h0);
                irq_is(1'b0);
            end else begin
                push_rx(4 * k - 1, fb);
                irq_is(1'b0);
                push_rx(1, junk);
                irq_is(1'b1);
                rd(tir_pkg::ADDR_RXBUF, {25'h0, fb});
                irq_is(1'b0);
            end
        end
        wr(tir_pkg::ADDR_CTRL, 32'h15);
        push_rx(4, junk);
        irq_is(1'b0);
        pins_are({23'h0, 1'b1, 1'b1, tw});
        wr(tir_pkg::ADDR_CTRL, 32'h10);
        bitcheck_ok <= 1'b1;
        @(posedge ref_clk);
        bitcheck_ok <= 1'b0;
        irq_is(1'b1);
        rd(tir_pkg::ADDR_STATUS, 33'h3520);
        wr(tir_pkg::ADDR_CMD, 32'h1);
        irq_is(1'b0);
        wr(tir_pkg::ADDR_CTRL, 32'h12);
        bitcheck_ok <= 1'b1;
        @(posedge ref_clk);
        bitcheck_ok <= 1'b0;
        irq_is(1'b0);
        pins_are({23'h0, 1'b0, 1'b0, tw});
        give_verdict;
    end
endmodule // transceiver_irq_logic_test
